// >>> rfq_free_queue_manager.sv
// Purpose: receive free-queue manager with AXI4-Lite registers
// Assumes: single memory read port with one-cycle acknowledge
// Notes:   one entry fetched per request
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module rfq_free_queue_manager
   import rfq_pkg::*;
(
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic [11:0]              s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [11:0]              s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire logic                     fetch_req,
   input  wire logic                     fetch_small,
   output logic                          fetch_done,
   output logic                          fetch_error,
   output logic [31:0]                   fetch_buf_addr,
   output logic [31:0]                   fetch_desc_addr,
   output logic [15:0]                   fetch_desc_index,
   output logic [rfq_pkg::SIZE_W-1:0]    fetch_buf_size,
   output logic                          mem_rd_req,
   output logic [31:0]                   mem_rd_addr,
   input  wire logic                     mem_rd_ack,
   input  wire logic [31:0]              mem_rd_data,
   output logic                          irq
);
   import rfq_pkg::*;

   // register file
   logic [15:0] base_lo_q, base_lo_d, base_hi_q, base_hi_d;
   logic [15:0] end_q, end_d, sstart_q, sstart_d;
   logic [15:0] lwp_q, lwp_d, swp_q, swp_d, lrp_q, lrp_d, srp_q, srp_d;
   logic [15:0] desc_lo_q, desc_lo_d, desc_hi_q, desc_hi_d;
   logic [SIZE_W-1:0] lsize_q, lsize_d, ssize_q, ssize_d;
   logic        dma_en_q, dma_en_d;
   logic [3:0]  flags_q, flags_d, inten_q, inten_d, flag_set;
   logic        irq_q, irq_d;
   // bus slave
   logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
   logic [11:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0]  wstrb_q, wstrb_d;
   logic        awready_q, awready_d, wready_q, wready_d;
   logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic        commit;
   // fetch engine
   rfq_state_t  state_q, state_d;
   logic        sel_small_q, sel_small_d;
   logic        done_q, done_d, err_q, err_d;
   logic [31:0] buf_q, buf_d, desc_q, desc_d;
   logic [15:0] idx_q, idx_d;
   logic [SIZE_W-1:0] size_q, size_d;
   logic        req_q, req_d;
   logic [31:0] addr_q, addr_d;
   logic        rp_adv_large, rp_adv_small;
   logic [15:0] rp_next;

   // merge a 16-bit field with byte lanes 0 and 1
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = data[7:0];
      end
      if (strb[1]) begin
         r[15:8] = data[15:8];
      end
      return r;
   endfunction

   // entry count to byte offset
   function automatic logic [31:0] entry_off(input logic [15:0] n);
      return 32'(n) << ENTRY_SHIFT;
   endfunction

   function automatic logic is_mapped(input logic [11:0] a);
      unique case (a)
         OFF_BASE_LOW, OFF_BASE_HIGH, OFF_END_INDEX, OFF_SMALL_START,
         OFF_LARGE_WP, OFF_SMALL_WP, OFF_LARGE_RP, OFF_SMALL_RP,
         OFF_CONTROL, OFF_STATUS, OFF_INT_ENABLE, OFF_LARGE_SIZE,
         OFF_SMALL_SIZE, OFF_DESC_LOW, OFF_DESC_HIGH: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   logic [31:0] base_addr, desc_base;
   assign base_addr = {base_hi_q, base_lo_q};
   assign desc_base = {desc_hi_q, desc_lo_q};

   // bus channel handshakes
   always_comb begin
      aw_hold_d = aw_hold_q;
      w_hold_d  = w_hold_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      arready_d = arready_q;
      rvalid_d  = rvalid_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      commit    = 1'b0;
      if (s_axi_awvalid && awready_q) begin
         aw_hold_d = 1'b1;
         awaddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
         w_hold_d = 1'b1;
         wdata_d  = s_axi_wdata;
         wstrb_d  = s_axi_wstrb;
      end
      if (aw_hold_q && w_hold_q && !bvalid_q) begin
         commit    = 1'b1;
         aw_hold_d = 1'b0;
         w_hold_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      awready_d = !aw_hold_d && !bvalid_d;
      wready_d  = !w_hold_d && !bvalid_d;
      if (s_axi_arvalid && arready_q) begin
         arready_d = 1'b0;
         rvalid_d  = 1'b1;
         rresp_d   = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr)
            OFF_BASE_LOW:    rdata_d = {16'h0000, base_lo_q};
            OFF_BASE_HIGH:   rdata_d = {16'h0000, base_hi_q};
            OFF_END_INDEX:   rdata_d = {16'h0000, end_q};
            OFF_SMALL_START: rdata_d = {16'h0000, sstart_q};
            OFF_LARGE_WP:    rdata_d = {16'h0000, lwp_q};
            OFF_SMALL_WP:    rdata_d = {16'h0000, swp_q};
            OFF_LARGE_RP:    rdata_d = {16'h0000, lrp_q};
            OFF_SMALL_RP:    rdata_d = {16'h0000, srp_q};
            OFF_CONTROL:     rdata_d = {31'h0000_0000, dma_en_q};
            OFF_STATUS:      rdata_d = {28'h000_0000, flags_q};
            OFF_INT_ENABLE:  rdata_d = {28'h000_0000, inten_q};
            OFF_LARGE_SIZE:  rdata_d = {19'h0_0000, lsize_q};
            OFF_SMALL_SIZE:  rdata_d = {19'h0_0000, ssize_q};
            OFF_DESC_LOW:    rdata_d = {16'h0000, desc_lo_q};
            OFF_DESC_HIGH:   rdata_d = {16'h0000, desc_hi_q};
            default:         rdata_d = 32'h0000_0000;
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d  = 1'b0;
         arready_d = 1'b1;
      end else if (!rvalid_q) begin
         arready_d = 1'b1;
      end
   end

   // register writes and status
   always_comb begin
      base_lo_d = base_lo_q;
      base_hi_d = base_hi_q;
      end_d     = end_q;
      sstart_d  = sstart_q;
      lwp_d     = lwp_q;
      swp_d     = swp_q;
      lrp_d     = lrp_q;
      srp_d     = srp_q;
      desc_lo_d = desc_lo_q;
      desc_hi_d = desc_hi_q;
      lsize_d   = lsize_q;
      ssize_d   = ssize_q;
      dma_en_d  = dma_en_q;
      inten_d   = inten_q;
      flags_d   = flags_q;
      if (commit) begin
         unique case (awaddr_q)
            OFF_BASE_LOW:    base_lo_d = merge16(base_lo_q, wdata_q, wstrb_q);
            OFF_BASE_HIGH:   base_hi_d = merge16(base_hi_q, wdata_q, wstrb_q);
            OFF_END_INDEX:   end_d = merge16(end_q, wdata_q, wstrb_q);
            OFF_SMALL_START: sstart_d = merge16(sstart_q, wdata_q, wstrb_q);
            OFF_LARGE_WP:    lwp_d = merge16(lwp_q, wdata_q, wstrb_q);
            OFF_SMALL_WP:    swp_d = merge16(swp_q, wdata_q, wstrb_q);
            OFF_LARGE_RP:    if (!dma_en_q) lrp_d = merge16(lrp_q, wdata_q, wstrb_q);
            OFF_SMALL_RP:    if (!dma_en_q) srp_d = merge16(srp_q, wdata_q, wstrb_q);
            OFF_CONTROL:     if (wstrb_q[0]) dma_en_d = wdata_q[CTRL_RX_DMA_EN_BIT];
            OFF_STATUS:      if (wstrb_q[0]) flags_d = flags_q & ~wdata_q[3:0];
            OFF_INT_ENABLE:  if (wstrb_q[0]) inten_d = wdata_q[3:0];
            OFF_LARGE_SIZE: lsize_d = SIZE_W'(merge16({3'b000, lsize_q}, wdata_q, wstrb_q));
            OFF_SMALL_SIZE: ssize_d = SIZE_W'(merge16({3'b000, ssize_q}, wdata_q, wstrb_q));
            OFF_DESC_LOW:   desc_lo_d = merge16(desc_lo_q, wdata_q, wstrb_q);
            OFF_DESC_HIGH:  desc_hi_d = merge16(desc_hi_q, wdata_q, wstrb_q);
            default: begin
            end
         endcase
      end
      if (rp_adv_large) begin
         lrp_d = rp_next;
      end
      if (rp_adv_small) begin
         srp_d = rp_next;
      end
      flags_d = flags_d | flag_set;
      irq_d   = |(flags_q & inten_q);
   end

   // fetch engine
   always_comb begin
      logic        empty;
      logic [15:0] rp, wp, limit, inc;
      empty        = 1'b0;
      rp           = sel_small_q ? srp_q : lrp_q;
      wp           = sel_small_q ? swp_q : lwp_q;
      limit        = sel_small_q ? end_q : sstart_q;
      inc          = rp + 16'h0001;
      state_d      = state_q;
      sel_small_d  = sel_small_q;
      done_d       = 1'b0;
      err_d        = err_q;
      buf_d        = buf_q;
      desc_d       = desc_q;
      idx_d        = idx_q;
      size_d       = size_q;
      req_d        = req_q;
      addr_d       = addr_q;
      flag_set     = RST_FLAGS;
      rp_adv_large = 1'b0;
      rp_adv_small = 1'b0;
      rp_next      = (inc >= limit) ? 16'h0000 : inc;
      unique case (state_q)
         ST_IDLE: begin
            if (fetch_req && dma_en_q && !done_q) begin
               sel_small_d = fetch_small;
               rp = fetch_small ? srp_q : lrp_q;
               wp = fetch_small ? swp_q : lwp_q;
               empty = (rp == wp);
               if (empty) begin
                  done_d = 1'b1;
                  err_d  = 1'b1;
                  flag_set[fetch_small ? FLAG_SMALL_UFLOW : FLAG_LARGE_UFLOW] = 1'b1;
               end else begin
                  err_d   = 1'b0;
                  req_d   = 1'b1;
                  state_d = ST_WORD0;
                  if (fetch_small) begin
                     addr_d = base_addr + entry_off(sstart_q) + entry_off(rp);
                  end else begin
                     addr_d = base_addr + entry_off(rp);
                  end
               end
            end
         end
         ST_WORD0: begin
            if (mem_rd_ack) begin
               buf_d   = mem_rd_data;
               addr_d  = addr_q + WORD_STEP;
               state_d = ST_WORD1;
            end
         end
         ST_WORD1: begin
            if (mem_rd_ack) begin
               req_d   = 1'b0;
               idx_d   = mem_rd_data[15:0];
               desc_d  = desc_base + (32'(mem_rd_data[15:0]) << DESC_SHIFT);
               size_d  = sel_small_q ? ssize_q : lsize_q;
               done_d  = 1'b1;
               state_d = ST_IDLE;
               rp_adv_large = !sel_small_q;
               rp_adv_small = sel_small_q;
               flag_set[sel_small_q ? FLAG_SMALL_FETCH : FLAG_LARGE_FETCH] = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         base_lo_q   <= RST_REG16;
         base_hi_q   <= RST_REG16;
         end_q       <= RST_REG16;
         sstart_q    <= RST_REG16;
         lwp_q       <= RST_REG16;
         swp_q       <= RST_REG16;
         lrp_q       <= RST_REG16;
         srp_q       <= RST_REG16;
         desc_lo_q   <= RST_REG16;
         desc_hi_q   <= RST_REG16;
         lsize_q     <= RST_SIZE;
         ssize_q     <= RST_SIZE;
         dma_en_q    <= 1'b0;
         flags_q     <= RST_FLAGS;
         inten_q     <= RST_FLAGS;
         irq_q       <= 1'b0;
         aw_hold_q   <= 1'b0;
         w_hold_q    <= 1'b0;
         awaddr_q    <= 12'h000;
         wdata_q     <= 32'h0000_0000;
         wstrb_q     <= 4'h0;
         awready_q   <= 1'b0;
         wready_q    <= 1'b0;
         bvalid_q    <= 1'b0;
         bresp_q     <= RESP_OKAY;
         arready_q   <= 1'b0;
         rvalid_q    <= 1'b0;
         rresp_q     <= RESP_OKAY;
         rdata_q     <= 32'h0000_0000;
         state_q     <= ST_IDLE;
         sel_small_q <= 1'b0;
         done_q      <= 1'b0;
         err_q       <= 1'b0;
         buf_q       <= 32'h0000_0000;
         desc_q      <= 32'h0000_0000;
         idx_q       <= 16'h0000;
         size_q      <= RST_SIZE;
         req_q       <= 1'b0;
         addr_q      <= 32'h0000_0000;
      end else begin
         base_lo_q   <= base_lo_d;
         base_hi_q   <= base_hi_d;
         end_q       <= end_d;
         sstart_q    <= sstart_d;
         lwp_q       <= lwp_d;
         swp_q       <= swp_d;
         lrp_q       <= lrp_d;
         srp_q       <= srp_d;
         desc_lo_q   <= desc_lo_d;
         desc_hi_q   <= desc_hi_d;
         lsize_q     <= lsize_d;
         ssize_q     <= ssize_d;
         dma_en_q    <= dma_en_d;
         flags_q     <= flags_d;
         inten_q     <= inten_d;
         irq_q       <= irq_d;
         aw_hold_q   <= aw_hold_d;
         w_hold_q    <= w_hold_d;
         awaddr_q    <= awaddr_d;
         wdata_q     <= wdata_d;
         wstrb_q     <= wstrb_d;
         awready_q   <= awready_d;
         wready_q    <= wready_d;
         bvalid_q    <= bvalid_d;
         bresp_q     <= bresp_d;
         arready_q   <= arready_d;
         rvalid_q    <= rvalid_d;
         rresp_q     <= rresp_d;
         rdata_q     <= rdata_d;
         state_q     <= state_d;
         sel_small_q <= sel_small_d;
         done_q      <= done_d;
         err_q       <= err_d;
         buf_q       <= buf_d;
         desc_q      <= desc_d;
         idx_q       <= idx_d;
         size_q      <= size_d;
         req_q       <= req_d;
         addr_q      <= addr_d;
      end
   end

   assign s_axi_awready    = awready_q;
   assign s_axi_wready     = wready_q;
   assign s_axi_bvalid     = bvalid_q;
   assign s_axi_bresp      = bresp_q;
   assign s_axi_arready    = arready_q;
   assign s_axi_rvalid     = rvalid_q;
   assign s_axi_rresp      = rresp_q;
   assign s_axi_rdata      = rdata_q;
   assign fetch_done       = done_q;
   assign fetch_error      = err_q;
   assign fetch_buf_addr   = buf_q;
   assign fetch_desc_addr  = desc_q;
   assign fetch_desc_index = idx_q;
   assign fetch_buf_size   = size_q;
   assign mem_rd_req       = req_q;
   assign mem_rd_addr      = addr_q;
   assign irq              = irq_q;
endmodule
`default_nettype wire

// >>> rfq_pkg.sv
// Purpose: constants for the receive free-queue manager
// Assumes: 32-bit AXI4-Lite register bus, 125 MHz aclk
// Notes:   offsets are byte addresses
package rfq_pkg;
   localparam int PTR_W = 16;
   localparam int SIZE_W = 13;
   // register byte offsets
   localparam logic [11:0] OFF_BASE_LOW    = 12'h0700;
   localparam logic [11:0] OFF_BASE_HIGH   = 12'h0704;
   localparam logic [11:0] OFF_END_INDEX   = 12'h0708;
   localparam logic [11:0] OFF_SMALL_START = 12'h070c;
   localparam logic [11:0] OFF_LARGE_WP    = 12'h0710;
   localparam logic [11:0] OFF_SMALL_WP    = 12'h0714;
   localparam logic [11:0] OFF_LARGE_RP    = 12'h0718;
   localparam logic [11:0] OFF_SMALL_RP    = 12'h071c;
   localparam logic [11:0] OFF_CONTROL     = 12'h0720;
   localparam logic [11:0] OFF_STATUS      = 12'h0724;
   localparam logic [11:0] OFF_INT_ENABLE  = 12'h0728;
   localparam logic [11:0] OFF_LARGE_SIZE  = 12'h072c;
   localparam logic [11:0] OFF_SMALL_SIZE  = 12'h0730;
   localparam logic [11:0] OFF_DESC_LOW    = 12'h0750;
   localparam logic [11:0] OFF_DESC_HIGH   = 12'h0754;
   // field positions
   localparam int CTRL_RX_DMA_EN_BIT = 0;
   localparam int FLAG_LARGE_FETCH   = 0;
   localparam int FLAG_SMALL_FETCH   = 1;
   localparam int FLAG_LARGE_UFLOW   = 2;
   localparam int FLAG_SMALL_UFLOW   = 3;
   // reset values
   localparam logic [15:0] RST_REG16 = 16'h0000;
   localparam logic [3:0]  RST_FLAGS = 4'h0;
   localparam logic [SIZE_W-1:0] RST_SIZE = 13'h0000;
   // entry geometry
   localparam int ENTRY_SHIFT = 3;
   localparam int DESC_SHIFT  = 4;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_WORD0 = 3'b010,
      ST_WORD1 = 3'b100
   } rfq_state_t;
endpackage

// >>> rfq_free_queue_manager_props.sv
// Purpose: port checker for the free-queue manager
// Assumes: single clock, synchronous active-low reset
// Notes:   queue base is 8-byte aligned
`timescale 1ns/10ps
`default_nettype none
module rfq_fqm_props (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        fetch_req,
   input wire logic        fetch_done,
   input wire logic        fetch_error,
   input wire logic        mem_rd_req,
   input wire logic        mem_rd_ack,
   input wire logic [31:0] mem_rd_addr,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_start; $rose(mem_rd_req) |-> $past(fetch_req); endproperty
   a_start: assert property (p_start) else $error("read without request");
   property p_hold; mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr); endproperty
   a_hold: assert property (p_hold) else $error("read request not held");
   property p_word1;
      mem_rd_req && mem_rd_ack && !mem_rd_addr[2]
         |=> mem_rd_req && mem_rd_addr == $past(mem_rd_addr) + 32'h0000_0004;
   endproperty
   a_word1: assert property (p_word1) else $error("second word address wrong");
   property p_end;
      mem_rd_req && mem_rd_ack && mem_rd_addr[2] |=> !mem_rd_req && fetch_done && !fetch_error;
   endproperty
   a_end: assert property (p_end) else $error("fetch not finished after entry");
   property p_empty; fetch_done && fetch_error |-> !$past(mem_rd_req); endproperty
   a_empty: assert property (p_empty) else $error("empty queue was read");
   property p_good; fetch_done && !fetch_error |-> $past(mem_rd_ack) && $past(mem_rd_req); endproperty
   a_good: assert property (p_good) else $error("fetch done without read");
   property p_pulse; fetch_done |=> !fetch_done; endproperty
   a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
   property p_rdata; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rdata: assert property (p_rdata) else $error("read data not held");
endmodule
bind rfq_free_queue_manager rfq_fqm_props u_props (.aclk, .aresetn, .fetch_req, .fetch_done,
   .fetch_error, .mem_rd_req, .mem_rd_ack, .mem_rd_addr, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata);
`default_nettype wire

// >>> rfq_mem_model.sv
// Purpose: host memory holding free-queue entries
// Assumes: entry contents derive from the entry address
// Notes:   delay sets wait cycles before each acknowledge
`timescale 1ns/10ps
`default_nettype none
module rfq_mem_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  delay,
   input  wire logic        mem_rd_req,
   input  wire logic [31:0] mem_rd_addr,
   output logic             mem_rd_ack,
   output logic [31:0]      mem_rd_data
);
   logic [3:0] wait_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_rd_ack  <= 1'b0;
         wait_q      <= 4'h0;
         mem_rd_data <= 32'h5a5a_5a5a;
      end else if (mem_rd_ack || !mem_rd_req || wait_q != delay) begin
         // data toggles outside an acknowledge
         mem_rd_ack  <= 1'b0;
         wait_q      <= (mem_rd_req && !mem_rd_ack) ? wait_q + 4'h1 : 4'h0;
         mem_rd_data <= ~mem_rd_data;
      end else begin
         mem_rd_ack  <= 1'b1;
         wait_q      <= 4'h0;
         // buffer address, then index with junk above
         mem_rd_data <= mem_rd_addr[2] ? {~mem_rd_addr[31:16], mem_rd_addr[18:3]} : ~mem_rd_addr;
      end
   end
endmodule
`default_nettype wire

// >>> rfq_free_queue_manager_tb.sv
// Purpose: self-checking bench for the free-queue manager
// Assumes: aligned queue base, partner memory model
// Notes:   rows cover fetch, wrap and underflow
`timescale 1ns/10ps
`default_nettype none
module rfq_free_queue_manager_tb;
   import rfq_pkg::*;
   localparam logic [31:0] BASE = 32'h0001_0000;
   localparam logic [31:0] DESC = 32'h0020_0000;
   localparam logic [11:0] CA [14] = '{OFF_BASE_LOW, OFF_BASE_HIGH, OFF_END_INDEX,
      OFF_SMALL_START, OFF_LARGE_WP, OFF_SMALL_WP, OFF_LARGE_RP, OFF_SMALL_RP, OFF_LARGE_SIZE,
      OFF_SMALL_SIZE, OFF_DESC_LOW, OFF_DESC_HIGH, OFF_INT_ENABLE, OFF_CONTROL};
   localparam logic [31:0] CD [14] = '{32'h0, 32'h1, 32'h6, 32'h4, 32'h1, 32'h0, 32'h2, 32'h5,
      32'h200, 32'h80, 32'h0, 32'h20, 32'hf, 32'h1};
   // small, error, read pointer before the fetch
   localparam logic [4:0]  ROWS [6] = '{5'h02, 5'h03, 5'h15, 5'h00, 5'h09, 5'h18};
   logic        aclk = 1'b0, aresetn = 1'b0, fetch_req = 1'b0, fetch_small = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'hf, delay = 4'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, fetch_buf_addr, fetch_desc_addr, mem_rd_addr, mem_rd_data;
   logic        fetch_done, fetch_error, mem_rd_req, mem_rd_ack, irq;
   logic [15:0] fetch_desc_index;
   logic [SIZE_W-1:0] fetch_buf_size;
   int          n_errors = 0, num_checks = 0, cyc = 0;
   rfq_free_queue_manager dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_req, .fetch_small, .fetch_done,
      .fetch_error, .fetch_buf_addr, .fetch_desc_addr, .fetch_desc_index, .fetch_buf_size,
      .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .irq);
   rfq_mem_model u_mem (.aclk, .aresetn, .delay, .mem_rd_req, .mem_rd_addr, .mem_rd_ack,
      .mem_rd_data);
   always #4 aclk = ~aclk;
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         give_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         aw |= s_axi_awready;
         w |= s_axi_wready;
      end while (!(aw && w));
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", 32'(er), 32'(s_axi_bresp));
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp,
                       input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(nm, exp, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
   endtask
   task automatic fetch(input logic sm);
      @(posedge aclk);
      fetch_req <= 1'b1;
      fetch_small <= sm;
      do @(posedge aclk); while (!fetch_done);
      fetch_req <= 1'b0;
   endtask
   initial begin
      logic        sm, er;
      logic [15:0] rp;
      logic [31:0] ea;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      for (int i = 0; i < 14; i++) rchk("reset value", CA[i], 32'h0, RESP_OKAY);
      for (int i = 0; i < 14; i++) wr(CA[i], CD[i], RESP_OKAY);
      for (int i = 0; i < 14; i++) rchk("readback", CA[i], CD[i], RESP_OKAY);
      $display("register test done");
      for (int i = 0; i < 6; i++) begin
         sm = ROWS[i][4];
         er = ROWS[i][3];
         rp = 16'(ROWS[i][2:0]);
         delay <= 4'(3 * (i % 2));
         fetch(sm);
         ea = BASE + (sm ? 32'h20 : 32'h0) + 32'(rp) * 8;
         chk("fetch_error", 32'(er), 32'(fetch_error));
         if (!er) begin
            chk("buf_addr", ~ea, fetch_buf_addr);
            chk("desc_index", 32'(ea[18:3]), 32'(fetch_desc_index));
            chk("desc_addr", DESC + 32'(ea[18:3]) * 16, fetch_desc_addr);
            chk("buf_size", sm ? 32'h80 : 32'h200, 32'(fetch_buf_size));
            rp = (rp + 16'h1 >= (sm ? 16'h6 : 16'h4)) ? 16'h0 : rp + 16'h1;
         end
         rchk("read_ptr", sm ? OFF_SMALL_RP : OFF_LARGE_RP, 32'(rp), RESP_OKAY);
         rchk("status", OFF_STATUS, 32'h1 << (sm + 2 * er), RESP_OKAY);
         chk("irq", 32'h1, 32'(irq));
         wr(OFF_STATUS, 32'hf, RESP_OKAY);
         $display("row %0d done", i);
      end
      wr(OFF_LARGE_RP, 32'h3, RESP_OKAY);
      rchk("read_ptr locked", OFF_LARGE_RP, 32'h1, RESP_OKAY);
      wr(12'h7f0, 32'h1234_5678, RESP_SLVERR);
      rchk("unmapped", 12'h7f0, 32'h0, RESP_SLVERR);
      $display("access test done");
      wr(OFF_CONTROL, 32'h0, RESP_OKAY);
      wr(OFF_INT_ENABLE, 32'h0, RESP_OKAY);
      wr(OFF_LARGE_WP, 32'h2, RESP_OKAY);
      @(posedge aclk);
      fetch_req <= 1'b1;
      fetch_small <= 1'b0;
      repeat (20) begin
         @(posedge aclk);
         chk("fetch while off", 32'h0, 32'(fetch_done | mem_rd_req));
      end
      fetch_req <= 1'b0;
      wr(OFF_CONTROL, 32'h1, RESP_OKAY);
      fetch(1'b0);
      chk("buf_addr", ~(BASE + 32'h8), fetch_buf_addr);
      fetch(1'b0);
      chk("fetch_error", 32'h1, 32'(fetch_error));
      repeat (30) @(posedge aclk);
      chk("irq masked", 32'h0, 32'(irq));
      rchk("status kept", OFF_STATUS, 32'h5, RESP_OKAY);
      $display("enable test done");
      wr(OFF_CONTROL, 32'h0, RESP_OKAY);
      wr(OFF_SMALL_START, 32'h6, RESP_OKAY);
      wr(OFF_LARGE_RP, 32'h5, RESP_OKAY);
      wr(OFF_LARGE_WP, 32'h0, RESP_OKAY);
      wr(OFF_CONTROL, 32'h1, RESP_OKAY);
      fetch(1'b0);
      chk("buf_addr", ~(BASE + 32'h28), fetch_buf_addr);
      rchk("read_ptr", OFF_LARGE_RP, 32'h0, RESP_OKAY);
      $display("single size test done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      chk("buf_addr in reset", 32'h0, fetch_buf_addr);
      chk("outputs in reset", 32'h0, 32'({fetch_done, fetch_error, mem_rd_req, irq}));
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rchk("status after reset", OFF_STATUS, 32'h0, RESP_OKAY);
      rchk("control after reset", OFF_CONTROL, 32'h0, RESP_OKAY);
      $display("reset test done");
      give_verdict();
   end
endmodule
`default_nettype wire
